// File: hdl/cspr_core.sv
// Core special registers: pointers, accumulator, pc low, table, flags
// How it works
// RULE_01 - Indirect port zero uses sector-zero pointer, sector 0 only.
// RULE_02 - Ports one and two use low pointer within pointer sector byte.
// RULE_03 - All five pointer bytes are ordinary readable, writable storage.
// RULE_04 - Extended address: upper byte picks sector, low byte location.
// RULE_05 - Writing pc low byte replaces only low eight pc bits.
// RULE_06 - Loading pc low byte inserts one dummy cycle.
// RULE_07 - Table read: high byte to table result, low byte to target.
// RULE_08 - Flag writes leave watchdog and powerdown flags unchanged.
// RULE_09 - Watchdog flag set by timeout, cleared by reset, clear, halt.
// RULE_10 - Powerdown flag cleared by reset or clear, set by halt.
// RULE_11 - Carry from add, no-borrow in subtract, rotate through carry.
// RULE_12 - Half carry from low nibble carry or no nibble borrow.
// RULE_13 - Zero flag follows whether result is zero.
// RULE_14 - Wrap flag is carry into msb xor carry out.
// RULE_15 - Signed compare flag is wrap flag xor result msb.
// RULE_16 - Chained zero: copy on sub, and on sbc, else keep.
// RULE_17 - Calls and interrupts push only return address, not flags.
// RULE_18 - ALU results go to accumulator; no register-to-register move.
// RULE_19 - Indirect port addresses read zero and ignore writes.
// RULE_20 - Flags update in the same cycle the result is captured.
`timescale 1ns/1ns
module cspr_core import cspr_pkg::*; #(
  parameter int MEM_WORDS = 256 // Storage bytes per sector modelled
) (
  input wire logic clk, // System clock
  input wire logic sys_rst, // Synchronous reset, high
  input wire logic clk_en, // Clock enable, freezes all state
  input wire logic [11:0] paddr, // APB address
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic wdt_timeout, // Watchdog time-out pulse
  input wire logic wdt_clear, // Watchdog-clear instruction pulse
  input wire logic halt_exec, // Halt instruction pulse
  input wire logic [15:0] rom_word, // Program word at table pointer
  output logic [15:0] rom_addr, // Table pointer pair
  output logic [CSPR_PC_W-1:0] pc_out, // Program counter
  output logic dummy_cycle, // Dummy cycle after pc load
  output logic [15:0] push_word // Word pushed on call
);
  logic [7:0] ptr0_reg, p1lo_reg, p1sc_reg, p2lo_reg, p2sc_reg;
  logic [7:0] acc_reg, tbpl_reg, tbph_reg, tbrh_reg, flag_reg;
  logic [CSPR_PC_W-1:0] pc_reg;
  logic dummy_reg;
  logic [15:0] push_reg;
  logic [7:0] mem_reg [MEM_WORDS];
  logic [15:0] adr_reg;
  logic [7:0] dat_reg;
  logic bus_access;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  cspr_op_t op;
  cspr_alu_t alu;
  cspr_addr_t tgt;
  logic [7:0] rd_val;
  logic [7:0] wr_val;
  logic do_wr;
  logic cmd_go;
  logic bus_setup;
  logic [7:0] flag_next;

  // Setup is decoded; writes land at the access edge with pready high
  assign bus_setup = psel && !penable;
  assign bus_access = psel && penable && pready_reg;
  assign cmd_go = clk_en && bus_access && pwrite && paddr == CSPR_APB_CMD;
  assign op = cspr_op_t'(pwdata[3:0]);

  cspr_decode u_dec (
    .addr(adr_reg),
    .ptr0(ptr0_reg),
    .p1_lo(p1lo_reg),
    .p1_sc(p1sc_reg),
    .p2_lo(p2lo_reg),
    .p2_sc(p2sc_reg),
    .res(tgt)
  );

  cspr_alu u_alu (
    .op(op),
    .a(acc_reg),
    .b(rd_val),
    .cin(flag_reg[CSPR_F_C]),
    .out(alu)
  );

  // Read of the resolved target; indirect port addresses read zero
  always_comb begin
    rd_val = CSPR_ZERO8;
    if (tgt.sector == CSPR_ZERO8) begin
      case (tgt.offs)
        CSPR_OFS_IND0, CSPR_OFS_IND1, CSPR_OFS_IND2:
          rd_val = CSPR_ZERO8; // see RULE_19
        CSPR_OFS_PTR0: rd_val = ptr0_reg; // see RULE_03
        CSPR_OFS_P1LO: rd_val = p1lo_reg;
        CSPR_OFS_P1SC: rd_val = p1sc_reg;
        CSPR_OFS_P2LO: rd_val = p2lo_reg;
        CSPR_OFS_P2SC: rd_val = p2sc_reg;
        CSPR_OFS_ACC: rd_val = acc_reg;
        CSPR_OFS_PCLO: rd_val = pc_reg[7:0];
        CSPR_OFS_TBPL: rd_val = tbpl_reg;
        CSPR_OFS_TBPH: rd_val = tbph_reg;
        CSPR_OFS_TBRH: rd_val = tbrh_reg;
        CSPR_OFS_FLAG: rd_val = flag_reg;
        default: rd_val = mem_reg[tgt.offs];
      endcase
    end else begin
      rd_val = mem_reg[tgt.offs];
    end
  end

  // Value written by store, table read or a bus write of the target byte
  always_comb begin
    do_wr = 1'b0;
    wr_val = acc_reg; // see RULE_18
    if (clk_en && bus_access && pwrite && paddr == CSPR_APB_DAT) begin
      do_wr = 1'b1;
      wr_val = pwdata[7:0]; // see RULE_03
    end else if (cmd_go) begin
      case (op)
        CSPR_OP_STA: do_wr = 1'b1;
        CSPR_OP_TBRD: begin
          do_wr = 1'b1;
          wr_val = rom_word[7:0]; // see RULE_07
        end
        default: do_wr = 1'b0;
      endcase
    end
  end

  // Pointer and table pointer storage
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ptr0_reg <= 8'h00;
      p1lo_reg <= 8'h00;
      p1sc_reg <= 8'h00;
      p2lo_reg <= 8'h00;
      p2sc_reg <= 8'h00;
      tbpl_reg <= 8'h00;
      tbph_reg <= 8'h00;
    end else if (do_wr && tgt.sector == CSPR_ZERO8) begin
      case (tgt.offs)
        CSPR_OFS_PTR0: ptr0_reg <= wr_val; // see RULE_03
        CSPR_OFS_P1LO: p1lo_reg <= wr_val;
        CSPR_OFS_P1SC: p1sc_reg <= wr_val;
        CSPR_OFS_P2LO: p2lo_reg <= wr_val;
        CSPR_OFS_P2SC: p2sc_reg <= wr_val;
        CSPR_OFS_TBPL: tbpl_reg <= wr_val;
        CSPR_OFS_TBPH: tbph_reg <= wr_val;
        default: ptr0_reg <= ptr0_reg;
      endcase
    end
  end

  // General storage, all sectors folded onto one array
  always_ff @(posedge clk) begin
    if (do_wr && !(tgt.sector == CSPR_ZERO8 && tgt.offs < 8'h10)) begin
      mem_reg[tgt.offs] <= wr_val; // see RULE_01
    end
  end

  // Accumulator: every ALU result lands here
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      acc_reg <= 8'h00;
    end else if (do_wr && tgt.sector == CSPR_ZERO8
                 && tgt.offs == CSPR_OFS_ACC) begin
      acc_reg <= wr_val;
    end else if (cmd_go && op != CSPR_OP_NOP && op != CSPR_OP_STA
                 && op != CSPR_OP_TBRD && op != CSPR_OP_CALL) begin
      acc_reg <= alu.res; // see RULE_18
    end
  end

  // Table result high byte
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tbrh_reg <= 8'h00;
    end else if (cmd_go && op == CSPR_OP_TBRD) begin
      tbrh_reg <= rom_word[15:8]; // see RULE_07
    end
  end

  // Program counter, low byte load, dummy cycle and call push
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pc_reg <= '0;
      dummy_reg <= 1'b0;
      push_reg <= 16'h0000;
    end else if (clk_en) begin
      dummy_reg <= 1'b0;
      if (do_wr && tgt.sector == CSPR_ZERO8
          && tgt.offs == CSPR_OFS_PCLO) begin
        pc_reg[7:0] <= wr_val; // see RULE_05
        dummy_reg <= 1'b1; // see RULE_06
      end else if (cmd_go && op == CSPR_OP_CALL) begin
        push_reg <= 16'(pc_reg); // see RULE_17
        pc_reg <= pwdata[8+CSPR_PC_W-1:8];
      end else if (!dummy_reg) begin
        pc_reg <= pc_reg + 1'b1;
      end
    end
  end

  // Flag register next value: ALU or software then system events
  always_comb begin
    flag_next = flag_reg;
    if (do_wr && tgt.sector == CSPR_ZERO8 && tgt.offs == CSPR_OFS_FLAG) begin
      flag_next = (wr_val & ~CSPR_SYS_MASK)
                | (flag_reg & CSPR_SYS_MASK); // see RULE_08
    end else if (cmd_go && op != CSPR_OP_NOP && op != CSPR_OP_STA
                 && op != CSPR_OP_TBRD && op != CSPR_OP_CALL
                 && op != CSPR_OP_MOVA) begin
      flag_next[CSPR_F_Z] = alu.z; // see RULE_20
      if (alu.arith) begin
        flag_next[CSPR_F_AC] = alu.ac;
        flag_next[CSPR_F_OV] = alu.ov;
        flag_next[CSPR_F_SC] = alu.sc;
      end
      flag_next[CSPR_F_C] = alu.c;
      if (alu.is_sub) begin
        flag_next[CSPR_F_CZ] = alu.z; // see RULE_16
      end else if (alu.is_sbc) begin
        flag_next[CSPR_F_CZ] = flag_reg[CSPR_F_CZ] & alu.z;
      end
    end
    // A time-out in the same cycle as a clear still sets the flag
    if (halt_exec) begin
      flag_next[CSPR_F_PDF] = 1'b1; // see RULE_10
      flag_next[CSPR_F_TO] = wdt_timeout; // see RULE_09
    end else if (wdt_clear) begin
      flag_next[CSPR_F_PDF] = 1'b0;
      flag_next[CSPR_F_TO] = wdt_timeout;
    end else if (wdt_timeout) begin
      flag_next[CSPR_F_TO] = 1'b1;
    end
  end

  // Flag register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flag_reg <= CSPR_FLAG_RST;
    end else if (clk_en) begin
      flag_reg <= flag_next;
    end
  end

  // APB control registers and read data
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      adr_reg <= 16'h0000;
      dat_reg <= 8'h00;
      prdata_reg <= 32'h0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else if (clk_en) begin
      pready_reg <= bus_setup;
      pslverr_reg <= 1'b0;
      if (bus_access && pwrite) begin
        case (paddr)
          CSPR_APB_ADR: adr_reg <= pwdata[15:0];
          CSPR_APB_CMD: dat_reg <= rd_val;
          default: dat_reg <= dat_reg;
        endcase
      end
      if (bus_setup) begin
        prdata_reg <= 32'h0;
        if (pwrite) begin
          case (paddr)
            CSPR_APB_ADR, CSPR_APB_CMD, CSPR_APB_OPS, CSPR_APB_ST,
            CSPR_APB_RES, CSPR_APB_PC, CSPR_APB_DAT: pslverr_reg <= 1'b0;
            default: pslverr_reg <= 1'b1;
          endcase
        end else begin
          case (paddr)
            CSPR_APB_ADR: prdata_reg <= {16'h0, adr_reg};
            CSPR_APB_OPS: prdata_reg <= {16'h0, tbrh_reg, acc_reg};
            CSPR_APB_ST: prdata_reg <= {24'h0, flag_reg};
            CSPR_APB_RES: prdata_reg <= {8'h0, p2sc_reg, p1sc_reg, ptr0_reg};
            CSPR_APB_PC: prdata_reg <= {19'h0, pc_reg};
            CSPR_APB_DAT: prdata_reg <= {24'h0, rd_val};
            CSPR_APB_CMD: prdata_reg <= {24'h0, dat_reg};
            default: pslverr_reg <= 1'b1;
          endcase
        end
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign rom_addr = {tbph_reg, tbpl_reg};
  assign pc_out = pc_reg;
  assign dummy_cycle = dummy_reg;
  assign push_word = push_reg;

  // Checks beside the logic
  sys_bits_a: assert property ( // see RULE_08
    @(posedge clk) disable iff (sys_rst)
    clk_en && do_wr && tgt.sector == CSPR_ZERO8
    && tgt.offs == CSPR_OFS_FLAG
    && !halt_exec && !wdt_clear && !wdt_timeout
    |=> $stable(flag_reg[5:4]))
    else $error("system flags written");
  halt_flags_a: assert property ( // see RULE_09 RULE_10
    @(posedge clk) disable iff (sys_rst)
    clk_en && halt_exec
    |=> flag_reg[4] && flag_reg[5] == $past(wdt_timeout))
    else $error("halt flags wrong");
  clr_pdf_a: assert property ( // see RULE_10
    @(posedge clk) disable iff (sys_rst)
    clk_en && wdt_clear && !halt_exec
    |=> !flag_reg[4])
    else $error("powerdown flag not cleared");
  timeout_set_a: assert property ( // see RULE_09
    @(posedge clk) disable iff (sys_rst)
    clk_en && wdt_timeout
    |=> flag_reg[5])
    else $error("timeout lost");
  pc_page_a: assert property ( // see RULE_05
    @(posedge clk) disable iff (sys_rst)
    clk_en && do_wr && tgt.sector == CSPR_ZERO8
    && tgt.offs == CSPR_OFS_PCLO
    |=> pc_reg[12:8] == $past(pc_reg[12:8]) && dummy_reg)
    else $error("pc page changed");
  dummy_hold_a: assert property ( // see RULE_06
    @(posedge clk) disable iff (sys_rst)
    clk_en && dummy_reg && !do_wr && !cmd_go |=> $stable(pc_reg))
    else $error("dummy cycle not inserted");
  sc_xor_a: assert property ( // see RULE_15
    @(posedge clk) disable iff (sys_rst)
    cmd_go && alu.arith && !halt_exec
    |=> flag_reg[7] == (flag_reg[3] ^ acc_reg[7]))
    else $error("signed compare flag wrong");
  zero_flag_a: assert property ( // see RULE_13
    @(posedge clk) disable iff (sys_rst)
    cmd_go && alu.arith
    |=> flag_reg[2] == (acc_reg == 8'h00))
    else $error("zero flag wrong");
  tbl_high_a: assert property ( // see RULE_07
    @(posedge clk) disable iff (sys_rst)
    cmd_go && op == CSPR_OP_TBRD
    |=> tbrh_reg == $past(rom_word[15:8]))
    else $error("table high wrong");
  bus_ready_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    clk_en && bus_setup |=> pready)
    else $error("no ready");
  tmo_cov: cover property (@(posedge clk) halt_exec && wdt_timeout);
  add_cov: cover property (@(posedge clk) cmd_go && op == CSPR_OP_ADD);
  sbc_cov: cover property (@(posedge clk) cmd_go && op == CSPR_OP_SBC);
  halt_cov: cover property (@(posedge clk) halt_exec ##1 wdt_clear);
  pcl_cov: cover property (@(posedge clk) dummy_reg);
endmodule // cspr_core

// File: hdl/cspr_pkg.sv
// Package with offsets, field positions and types of the core registers
package cspr_pkg;
  // Special register offsets inside sector 0 (byte offset within sector)
  localparam logic [7:0] CSPR_OFS_IND0 = 8'h00;
  localparam logic [7:0] CSPR_OFS_PTR0 = 8'h01;
  localparam logic [7:0] CSPR_OFS_IND1 = 8'h02;
  localparam logic [7:0] CSPR_OFS_P1LO = 8'h03;
  localparam logic [7:0] CSPR_OFS_P1SC = 8'h04;
  localparam logic [7:0] CSPR_OFS_ACC = 8'h05;
  localparam logic [7:0] CSPR_OFS_PCLO = 8'h06;
  localparam logic [7:0] CSPR_OFS_TBPL = 8'h07;
  localparam logic [7:0] CSPR_OFS_TBRH = 8'h08;
  localparam logic [7:0] CSPR_OFS_TBPH = 8'h09;
  localparam logic [7:0] CSPR_OFS_FLAG = 8'h0a;
  localparam logic [7:0] CSPR_OFS_IND2 = 8'h0c;
  localparam logic [7:0] CSPR_OFS_P2LO = 8'h0d;
  localparam logic [7:0] CSPR_OFS_P2SC = 8'h0e;
  // APB byte addresses of the control registers
  localparam logic [11:0] CSPR_APB_CMD = 12'h000;
  localparam logic [11:0] CSPR_APB_OPS = 12'h004;
  localparam logic [11:0] CSPR_APB_ST = 12'h008;
  localparam logic [11:0] CSPR_APB_RES = 12'h00c;
  localparam logic [11:0] CSPR_APB_PC = 12'h010;
  localparam logic [11:0] CSPR_APB_DAT = 12'h014;
  localparam logic [11:0] CSPR_APB_ADR = 12'h018;
  // Flag bit positions
  localparam int CSPR_F_C = 0;
  localparam int CSPR_F_AC = 1;
  localparam int CSPR_F_Z = 2;
  localparam int CSPR_F_OV = 3;
  localparam int CSPR_F_PDF = 4;
  localparam int CSPR_F_TO = 5;
  localparam int CSPR_F_CZ = 6;
  localparam int CSPR_F_SC = 7;
  localparam logic [7:0] CSPR_FLAG_RST = 8'h00;
  localparam logic [7:0] CSPR_SYS_MASK = 8'h30;
  localparam logic [7:0] CSPR_ZERO8 = 8'h00;
  localparam int CSPR_PC_W = 13;
  // Operation codes accepted on the command register
  typedef enum logic [3:0] {
    CSPR_OP_NOP = 4'h0, CSPR_OP_ADD = 4'h1, CSPR_OP_ADC = 4'h2,
    CSPR_OP_SUB = 4'h3, CSPR_OP_SBC = 4'h4, CSPR_OP_AND = 4'h5,
    CSPR_OP_OR = 4'h6, CSPR_OP_XOR = 4'h7, CSPR_OP_RLC = 4'h8,
    CSPR_OP_RRC = 4'h9, CSPR_OP_MOVA = 4'ha, CSPR_OP_STA = 4'hb,
    CSPR_OP_TBRD = 4'hc, CSPR_OP_CALL = 4'hd, CSPR_OP_RDM = 4'he
  } cspr_op_t;
  // Result of the ALU slice
  typedef struct packed {
    logic [7:0] res;
    logic c;
    logic ac;
    logic z;
    logic ov;
    logic sc;
    logic is_sub;
    logic is_sbc;
    logic arith;
  } cspr_alu_t;
  // Resolved data-memory access
  typedef struct packed {
    logic hit_mem;
    logic [7:0] sector;
    logic [7:0] offs;
  } cspr_addr_t;
endpackage : cspr_pkg

// File: hdl/cspr_alu.sv
// Combinational ALU with flag generation
`timescale 1ns/1ns
module cspr_alu import cspr_pkg::*; (
  input wire cspr_op_t op, // Operation
  input wire logic [7:0] a, // Accumulator operand
  input wire logic [7:0] b, // Memory operand
  input wire logic cin, // Carry flag in
  output cspr_alu_t out // Result and flags
);
  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] bb;
  logic ci;
  logic c7;
  // Add and subtract share one adder; subtract adds the complement
  always_comb begin
    out = '0;
    bb = b;
    ci = 1'b0;
    case (op)
      CSPR_OP_ADC: ci = cin;
      CSPR_OP_SUB: begin
        bb = ~b;
        ci = 1'b1;
      end
      CSPR_OP_SBC: begin
        bb = ~b;
        ci = cin;
      end
      default: ci = 1'b0;
    endcase
    sum = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
    nib = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
    c7 = a[7] ^ bb[7] ^ sum[7];
    out.c = cin;
    case (op)
      CSPR_OP_ADD, CSPR_OP_ADC, CSPR_OP_SUB, CSPR_OP_SBC: begin
        out.res = sum[7:0];
        out.c = sum[8]; // see RULE_11
        out.ac = nib[4]; // see RULE_12
        out.ov = c7 ^ sum[8]; // see RULE_14
        out.arith = 1'b1;
      end
      CSPR_OP_AND: out.res = a & b;
      CSPR_OP_OR: out.res = a | b;
      CSPR_OP_XOR: out.res = a ^ b;
      CSPR_OP_RLC: begin
        out.res = {b[6:0], cin};
        out.c = b[7]; // see RULE_11
      end
      CSPR_OP_RRC: begin
        out.res = {cin, b[7:1]};
        out.c = b[0]; // see RULE_11
      end
      default: out.res = b;
    endcase
    out.z = (out.res == CSPR_ZERO8); // see RULE_13
    out.sc = out.ov ^ out.res[7]; // see RULE_15
    out.is_sub = (op == CSPR_OP_SUB);
    out.is_sbc = (op == CSPR_OP_SBC);
  end
endmodule // cspr_alu

// File: hdl/cspr_decode.sv
// Resolves direct, indirect and extended data addresses
`timescale 1ns/1ns
module cspr_decode import cspr_pkg::*; (
  input wire logic [15:0] addr, // Wide address, sector in upper byte
  input wire logic [7:0] ptr0, // Sector-zero pointer
  input wire logic [7:0] p1_lo, // Pointer one low byte
  input wire logic [7:0] p1_sc, // Pointer one sector
  input wire logic [7:0] p2_lo, // Pointer two low byte
  input wire logic [7:0] p2_sc, // Pointer two sector
  output cspr_addr_t res // Resolved target
);
  // Indirect ports redirect through their pointers
  always_comb begin
    res.hit_mem = 1'b1;
    res.sector = addr[15:8]; // see RULE_04
    res.offs = addr[7:0];
    if (addr[15:8] == CSPR_ZERO8) begin
      case (addr[7:0])
        CSPR_OFS_IND0: begin
          res.sector = CSPR_ZERO8; // see RULE_01
          res.offs = ptr0;
        end
        CSPR_OFS_IND1: begin
          res.sector = p1_sc; // see RULE_02
          res.offs = p1_lo;
        end
        CSPR_OFS_IND2: begin
          res.sector = p2_sc; // see RULE_02
          res.offs = p2_lo;
        end
        default: res.hit_mem = 1'b1;
      endcase
    end
  end
endmodule // cspr_decode

// File: bench/cspr_core_tb.sv
// Self-checking testbench for the core special registers over APB
`timescale 1ns/1ns
module cspr_core_tb;
  import cspr_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic wdt_timeout = 1'b0;
  logic wdt_clear = 1'b0;
  logic halt_exec = 1'b0;
  logic [15:0] rom_word = 16'hbeef;
  logic [15:0] rom_addr;
  logic [CSPR_PC_W-1:0] pc_out;
  logic dummy_cycle;
  logic [15:0] push_word;
  logic [31:0] rd_q;
  logic err_q;
  logic clk_en = 1'b1;
  int error_cnt = 0;
  int checked = 0;

  always #5 clk = ~clk;

  // Device under test; the bench owns the clock enable
  cspr_core i_cspr_core (
    .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wdt_timeout(wdt_timeout), .wdt_clear(wdt_clear),
    .halt_exec(halt_exec), .rom_word(rom_word), .rom_addr(rom_addr),
    .pc_out(pc_out), .dummy_cycle(dummy_cycle), .push_word(push_word)
  );

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk("pready", 32'h1, 32'h0);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr_mem(input logic [15:0] a, input logic [7:0] d);
    apb(1'b1, CSPR_APB_ADR, {16'h0, a});
    apb(1'b1, CSPR_APB_DAT, {24'h0, d});
  endtask

  task automatic rd_mem(input string what, input logic [15:0] a,
                        input logic [7:0] exp);
    apb(1'b1, CSPR_APB_ADR, {16'h0, a});
    apb(1'b0, CSPR_APB_DAT, 32'h0);
    chk(what, {24'h0, exp}, {24'h0, rd_q[7:0]});
  endtask

  task automatic cmd(input cspr_op_t op, input logic [15:0] a);
    apb(1'b1, CSPR_APB_ADR, {16'h0, a});
    apb(1'b1, CSPR_APB_CMD, {28'h0, op});
  endtask

  task automatic rd_reg(input string what, input logic [11:0] a,
                        input logic [31:0] mask, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp & mask, rd_q & mask);
  endtask

  // Arithmetic chain and flag values
  task automatic t_alu();
    wr_mem(16'h0020, 8'h7f);
    wr_mem(16'h0021, 8'h01);
    wr_mem(16'h0022, 8'h80);
    wr_mem(16'h0023, 8'h00);
    cmd(CSPR_OP_MOVA, 16'h0020);
    rd_reg("acc mov", CSPR_APB_OPS, 32'hff, 32'h7f);
    cmd(CSPR_OP_ADD, 16'h0021);
    rd_reg("acc add", CSPR_APB_OPS, 32'hff, 32'h80);
    rd_reg("flags add", CSPR_APB_ST, 32'hff, 32'h0a);
    cmd(CSPR_OP_SUB, 16'h0022);
    rd_reg("flags sub", CSPR_APB_ST, 32'hff, 32'h47);
    cmd(CSPR_OP_SBC, 16'h0021);
    rd_reg("acc sbc", CSPR_APB_OPS, 32'hff, 32'hff);
    rd_reg("flags sbc", CSPR_APB_ST, 32'hff, 32'h80);
    cmd(CSPR_OP_RLC, 16'h0022);
    rd_reg("acc rlc", CSPR_APB_OPS, 32'hff, 32'h00);
    rd_reg("carry rlc", CSPR_APB_ST, 32'h01, 32'h01);
    cmd(CSPR_OP_STA, 16'h0024);
    rd_mem("store", 16'h0024, 8'h00);
    cmd(CSPR_OP_AND, 16'h0023);
    rd_reg("zero and", CSPR_APB_ST, 32'h44, 32'h04);
  endtask

  task automatic pulse(input int k);
    @(posedge clk);
    wdt_timeout <= (k == 0 || k == 3);
    wdt_clear <= (k == 1);
    halt_exec <= (k == 2 || k == 3);
    @(posedge clk);
    wdt_timeout <= 1'b0;
    wdt_clear <= 1'b0;
    halt_exec <= 1'b0;
    @(posedge clk);
  endtask

  // System flags resist writes and follow their events
  task automatic t_sys();
    wr_mem({8'h00, CSPR_OFS_FLAG}, 8'hff);
    rd_reg("flag write", CSPR_APB_ST, 32'hff, 32'hcf);
    pulse(3);
    rd_reg("halt tmo", CSPR_APB_ST, 32'h30, 32'h30);
    pulse(2);
    rd_reg("halt", CSPR_APB_ST, 32'h30, 32'h10);
    pulse(0);
    rd_reg("timeout", CSPR_APB_ST, 32'h30, 32'h30);
    wr_mem({8'h00, CSPR_OFS_FLAG}, 8'h00);
    rd_reg("flag clr", CSPR_APB_ST, 32'hff, 32'h30);
    pulse(1);
    rd_reg("wdt clear", CSPR_APB_ST, 32'h30, 32'h00);
  endtask

  // Pointer storage and indirect redirection
  task automatic t_ptr();
    wr_mem(16'h0025, 8'h5a);
    wr_mem(16'h0140, 8'h3c);
    wr_mem(16'h0141, 8'h77);
    rd_mem("extended", 16'h0140, 8'h3c);
    wr_mem({8'h00, CSPR_OFS_PTR0}, 8'h25);
    wr_mem({8'h00, CSPR_OFS_P1LO}, 8'h40);
    wr_mem({8'h00, CSPR_OFS_P1SC}, 8'h01);
    wr_mem({8'h00, CSPR_OFS_P2LO}, 8'h41);
    wr_mem({8'h00, CSPR_OFS_P2SC}, 8'h01);
    rd_mem("p1lo", {8'h00, CSPR_OFS_P1LO}, 8'h40);
    rd_mem("p2lo", {8'h00, CSPR_OFS_P2LO}, 8'h41);
    rd_reg("ptrs", CSPR_APB_RES, 32'hffffff, 32'h010125);
    rd_mem("ind0", {8'h00, CSPR_OFS_IND0}, 8'h5a);
    rd_mem("ind1", {8'h00, CSPR_OFS_IND1}, 8'h3c);
    rd_mem("ind2", {8'h00, CSPR_OFS_IND2}, 8'h77);
    wr_mem({8'h00, CSPR_OFS_IND1}, 8'h99);
    rd_mem("ind1 wr", 16'h0140, 8'h99);
    wr_mem({8'h00, CSPR_OFS_PTR0}, CSPR_OFS_IND0);
    wr_mem({8'h00, CSPR_OFS_IND0}, 8'h55);
    rd_mem("self ind", {8'h00, CSPR_OFS_IND0}, 8'h00);
  endtask

  // Table read and program counter low byte
  task automatic t_tbl_pc();
    wr_mem({8'h00, CSPR_OFS_TBPL}, 8'h34);
    wr_mem({8'h00, CSPR_OFS_TBPH}, 8'h12);
    @(negedge clk);
    chk("rom addr", 32'h1234, {16'h0, rom_addr});
    cmd(CSPR_OP_TBRD, 16'h0030);
    rd_reg("tbl high", CSPR_APB_OPS, 32'hff00, 32'hbe00);
    rd_mem("tbl low", 16'h0030, 8'hef);
    wr_mem({8'h00, CSPR_OFS_FLAG}, 8'h85);
    apb(1'b1, CSPR_APB_CMD, {11'h0, 13'h1234, 4'h0, 4'(CSPR_OP_CALL)});
    @(negedge clk);
    chk("call pc", 32'h1234, {19'h0, pc_out});
    // Pc runs on two edges before the next call lands: 1236 is pushed
    apb(1'b1, CSPR_APB_CMD, {11'h0, 13'h0200, 4'h0, 4'(CSPR_OP_CALL)});
    @(negedge clk);
    chk("push", 32'h1236, {16'h0, push_word});
    rd_reg("call flags", CSPR_APB_ST, 32'hff, 32'h85);
    wr_mem({8'h00, CSPR_OFS_PCLO}, 8'h56);
    @(negedge clk);
    chk("dummy", 32'h1, {31'h0, dummy_cycle});
    @(negedge clk);
    chk("pc low", 32'h0256, {19'h0, pc_out});
    // Clock enable low freezes the counter
    @(posedge clk);
    clk_en <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("freeze", 32'h0257, {19'h0, pc_out});
    @(posedge clk);
    clk_en <= 1'b1;
    apb(1'b0, 12'h01c, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err_q});
  endtask

  // Watchdog on the whole run
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    $display("MISMATCH watchdog expected done seen hang");
    summarize();
  end

  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    // Pc counts from the first edge after reset
    @(negedge clk);
    chk("pc rst", 32'h0, {19'h0, pc_out});
    rd_reg("pc read", CSPR_APB_PC, 32'h1fff, 32'h1);
    rd_reg("flags rst", CSPR_APB_ST, 32'hff, {24'h0, CSPR_FLAG_RST});
    t_alu();
    t_sys();
    t_ptr();
    t_tbl_pc();
    summarize();
  end
endmodule // cspr_core_tb
